// File: rtl/rnpd_pkg.sv
// How it works
// RULE_01 - a low level on the external reset input while the oscillator runs puts the device in reset.
// RULE_02 - low pulses on the reset input shorter than 10 ns are treated as spikes and ignored.
// RULE_03 - low pulses on the reset input longer than 100 ns pass the filter and reach the reset logic; code needs FILTER_CYCLES+1 low samples (150 ns).
// RULE_04 - the outside party should hold reset low for 100 ns plus two clock cycles for safe recognition.
// RULE_05 - the outside party keeps reset low until the configuration pins have settled.
// RULE_06 - a falling edge on the non-maskable trap input makes the cpu branch to its trap routine.
// RULE_07 - the power-down instruction with the trap input low enters power-down mode.
// RULE_08 - the power-down instruction with the trap input high is ignored and the cpu runs on.
// RULE_09 - at the end of an external reset the two configuration pins are sampled as startup values.
// RULE_10 - reset and trap inputs are synchronised to the cpu clock before any edge or release logic.
// RULE_11 - the sampled startup values are held constant until the next external reset.
package rnpd_pkg;
    localparam int CLOCK_HZ        = 20000000;
    localparam int PASS_TIME_NS    = 100;
    // longest time a pulse must pass: round down, at least one cycle
    localparam int PASS_CYCLES_RAW = PASS_TIME_NS * (CLOCK_HZ / 1000000) / 1000;
    localparam int PASS_CYCLES     = (PASS_CYCLES_RAW < 1) ? 1 : PASS_CYCLES_RAW;
    localparam logic [1:0] CONFIG_RESET = 2'h0;

    typedef enum logic [2:0] {
        RNPD_RUN    = 3'h1,
        RNPD_RESET  = 3'h2,
        RNPD_POWDN  = 3'h4
    } rnpd_state_e;
endpackage

// File: rtl/rnpd_top.sv
`timescale 1ns/1ps
module rnpd_top #(
    parameter int FILTER_CYCLES = rnpd_pkg::PASS_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       osc_running,
    input  wire logic       external_reset_in,
    input  wire logic       nmi_in,
    input  wire logic       power_down_instruction,
    input  wire logic       config_pin_a,
    input  wire logic       config_pin_b,
    output logic            device_reset,
    output logic            nmi_trap,
    output logic            power_down,
    output logic [1:0]      startup_config
);
    // the low counter is eight bits wide; a longer filter cannot be served
    // and a zero-length one would let every sampled spike through
    if (FILTER_CYCLES < 1 || FILTER_CYCLES > 255) begin : g_bad_filter
        $error("FILTER_CYCLES out of range");
    end

    logic [1:0]         rst_sync;
    logic [1:0]         nmi_sync;
    logic [1:0]         cfg_a_sync;
    logic [1:0]         cfg_b_sync;
    logic               nmi_prev;
    logic [7:0]         low_count;
    logic               rst_filtered;
    rnpd_pkg::rnpd_state_e state;

    // two-flop synchronisers; pins are asynchronous to the cpu clock
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_sync   <= 2'h3;
            nmi_sync   <= 2'h3;
            cfg_a_sync <= 2'h0;
            cfg_b_sync <= 2'h0;
        end else begin
            rst_sync   <= {rst_sync[0], external_reset_in}; // RULE_10
            nmi_sync   <= {nmi_sync[0], nmi_in}; // RULE_10
            cfg_a_sync <= {cfg_a_sync[0], config_pin_a};
            cfg_b_sync <= {cfg_b_sync[0], config_pin_b};
        end
    end

    // spike filter: a low must last FILTER_CYCLES+1 samples to count,
    // so sub-cycle spikes never reach the reset logic
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            low_count    <= 8'h00;
            rst_filtered <= 1'b0;
        end else if (rst_sync[1]) begin
            low_count    <= 8'h00; // RULE_02
            rst_filtered <= 1'b0;
        end else if (low_count < 8'(FILTER_CYCLES)) begin
            low_count    <= low_count + 8'h01;
        end else begin
            rst_filtered <= osc_running; // RULE_01 RULE_03
        end
    end

    // edge history for the trap input
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            nmi_prev <= 1'b1;
        else
            nmi_prev <= nmi_sync[1];
    end

    // trap pulse on a synchronised falling edge, not during reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            nmi_trap <= 1'b0;
        else
            nmi_trap <= nmi_prev && !nmi_sync[1]
                        && state == rnpd_pkg::RNPD_RUN; // RULE_06
    end

    // device state: reset wins over everything; power-down only wakes
    // through reset since this block sees no other wake source
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= rnpd_pkg::RNPD_RESET;
        end else if (rst_filtered) begin
            state <= rnpd_pkg::RNPD_RESET; // RULE_01
        end else begin
            case (state)
                rnpd_pkg::RNPD_RESET: begin
                    state <= rnpd_pkg::RNPD_RUN;
                end
                rnpd_pkg::RNPD_RUN: begin
                    if (power_down_instruction && !nmi_sync[1])
                        state <= rnpd_pkg::RNPD_POWDN; // RULE_07 RULE_08
                end
                rnpd_pkg::RNPD_POWDN: begin
                    state <= rnpd_pkg::RNPD_POWDN;
                end
                default: begin
                    state <= rnpd_pkg::RNPD_RESET;
                end
            endcase
        end
    end

    // configuration captured on the cycle reset releases
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            startup_config <= rnpd_pkg::CONFIG_RESET;
        else if (state == rnpd_pkg::RNPD_RESET && !rst_filtered)
            startup_config <= {cfg_b_sync[1], cfg_a_sync[1]}; // RULE_09 RULE_11
    end

    assign device_reset = (state == rnpd_pkg::RNPD_RESET);
    assign power_down   = (state == rnpd_pkg::RNPD_POWDN);

    // trap request: synchronised falling edge seen while running
    sequence s_nmi_fall;
        nmi_prev && !nmi_sync[1] && state == rnpd_pkg::RNPD_RUN;
    endsequence

    // power-down request that is allowed to take effect
    sequence s_pd_request;
        state == rnpd_pkg::RNPD_RUN && power_down_instruction
        && !nmi_sync[1] && !rst_filtered;
    endsequence

    // running with the trap input high: no request may stop the cpu
    sequence s_pd_blocked;
        state == rnpd_pkg::RNPD_RUN && nmi_sync[1] && !rst_filtered;
    endsequence

    // last reset cycle: the filter has gone quiet while still in reset
    sequence s_release;
        state == rnpd_pkg::RNPD_RESET && !rst_filtered;
    endsequence

    // a low that has outlasted the filter while the oscillator runs
    sequence s_long_low;
        osc_running && !rst_sync[1] && low_count >= 8'(FILTER_CYCLES);
    endsequence

    // every accepted edge gives a trap pulse on the next cycle
    a_nmi_trap_pulse: assert property ( // RULE_06
        @(posedge clock) disable iff (!resetn)
        s_nmi_fall |=> nmi_trap)
        else $error("trap missed after falling edge");

    // no trap pulse without a synchronised falling edge behind it
    a_trap_only_edge: assert property ( // RULE_06
        @(posedge clock) disable iff (!resetn)
        nmi_trap |-> $past(nmi_prev) && !$past(nmi_sync[1]))
        else $error("trap without falling edge");

    // a held-low trap pin must not retrigger the routine
    a_trap_one_cycle: assert property ( // RULE_06
        @(posedge clock) disable iff (!resetn)
        nmi_trap |=> !nmi_trap)
        else $error("trap pulse longer than one cycle");

    // the cpu takes no trap while held in reset or stopped
    a_trap_quiet: assert property ( // RULE_06
        @(posedge clock) disable iff (!resetn)
        state != rnpd_pkg::RNPD_RUN |=> !nmi_trap)
        else $error("trap raised outside run state");

    // a permitted request stops the cpu on the next cycle
    a_pd_enter_low: assert property ( // RULE_07
        @(posedge clock) disable iff (!resetn)
        s_pd_request |=> power_down)
        else $error("power-down not entered");

    // power-down is left only through reset
    a_pd_holds: assert property ( // RULE_07
        @(posedge clock) disable iff (!resetn)
        power_down && !rst_filtered |=> power_down)
        else $error("power-down left without reset");

    // with the trap input high the cpu keeps running
    a_pd_refused_high: assert property ( // RULE_08
        @(posedge clock) disable iff (!resetn)
        s_pd_blocked |=> !power_down)
        else $error("power-down entered with trap input high");

    // a filtered reset request always puts the device in reset
    a_reset_held: assert property ( // RULE_01
        @(posedge clock) disable iff (!resetn)
        rst_filtered |=> device_reset)
        else $error("reset not applied");

    // reset ends one cycle after the request goes away
    a_release_run: assert property ( // RULE_01
        @(posedge clock) disable iff (!resetn)
        s_release |=> !device_reset)
        else $error("reset held after request ended");

    // a stopped oscillator never lets the pin raise a reset request
    a_osc_blocks: assert property ( // RULE_01
        @(posedge clock) disable iff (!resetn)
        !osc_running |=> !rst_filtered)
        else $error("reset request with oscillator stopped");

    // a request needs at least two synchronised low samples behind it
    a_spike_blocked: assert property ( // RULE_02
        @(posedge clock) disable iff (!resetn)
        $rose(rst_filtered) |-> $past(!rst_sync[1], 1)
        && $past(!rst_sync[1], 2))
        else $error("short spike reached reset");

    // a low that outlasts the filter must reach the reset logic
    a_long_passes: assert property ( // RULE_03
        @(posedge clock) disable iff (!resetn)
        s_long_low |=> rst_filtered)
        else $error("long reset pulse blocked");

    // the release cycle takes the synchronised pin values
    a_cfg_capture: assert property ( // RULE_09
        @(posedge clock) disable iff (!resetn)
        s_release |=> startup_config == $past({cfg_b_sync[1], cfg_a_sync[1]}))
        else $error("startup config not sampled at release");

    // outside reset the sampled values never move
    a_config_stable: assert property ( // RULE_11
        @(posedge clock) disable iff (!resetn)
        !device_reset |=> $stable(startup_config))
        else $error("startup config changed outside reset");

    // a stopped oscillator also drops the request, so only falls with the
    // oscillator up must come from the synchronised pin
    a_sync_depth: assert property ( // RULE_10
        @(posedge clock) disable iff (!resetn)
        $fell(rst_filtered) && $past(osc_running) |-> $past(rst_sync[1]))
        else $error("reset released without synchronised high");
endmodule

// File: verif/rnpd_ext_model.sv
`timescale 1ns/1ps
// reset circuit and trap source; both lines idle high as if pulled up
module rnpd_ext_model (
    input  wire logic       clock,
    output logic            rst_pin_n,
    output logic            nmi_pin_n,
    output logic [1:0]      cfg_pins
);
    initial begin
        rst_pin_n = 1'b1;
        nmi_pin_n = 1'b1;
        cfg_pins  = 2'h0;
    end
    // pins set before the low so they settle long before release
    task automatic hold_reset(input int n, input logic [1:0] cfg);
        cfg_pins = cfg;
        @(posedge clock) #5 rst_pin_n = 1'b0;
        repeat (n) @(posedge clock);
        #5 rst_pin_n = 1'b1;
    endtask
    // a low far shorter than a clock period, landing between two edges
    task automatic glitch_reset();
        @(posedge clock) #5 rst_pin_n = 1'b0;
        #4 rst_pin_n = 1'b1;
    endtask
    task automatic set_trap(input logic v);
        @(posedge clock) #5 nmi_pin_n = v;
    endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic       clock, resetn, osc_running, pd_instr;
    logic       rst_n, nmi_n, device_reset, nmi_trap, power_down;
    logic [1:0] cfg, startup_config;
    int         bad_count = 0;
    int         tests_run = 0;
    int         seen;
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    rnpd_ext_model ext_u (.clock(clock), .rst_pin_n(rst_n),
        .nmi_pin_n(nmi_n), .cfg_pins(cfg));
    rnpd_top #(.FILTER_CYCLES(2)) dut_u (.clock(clock), .resetn(resetn),
        .osc_running(osc_running), .external_reset_in(rst_n),
        .nmi_in(nmi_n), .power_down_instruction(pd_instr),
        .config_pin_a(cfg[0]), .config_pin_b(cfg[1]),
        .device_reset(device_reset), .nmi_trap(nmi_trap),
        .power_down(power_down), .startup_config(startup_config));
    task automatic check(input string w, input logic [7:0] s, e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // count cycles with device_reset high over a fixed span
    task automatic watch(input int n);
        seen = 0;
        repeat (n) begin
            @(posedge clock) #5;
            seen += int'(device_reset === 1'b1);
        end
    endtask
    task automatic pulse_pd();
        pd_instr = 1'b1;
        @(posedge clock) #5 pd_instr = 1'b0;
        repeat (2) @(posedge clock);
        #5;
    endtask
    task automatic t_reset();
        ext_u.hold_reset(8, 2'h2);
        check("reset_held", device_reset, 1'b1);
        watch(6);
        check("reset_gone", device_reset, 1'b0);
        check("cfg_sampled", startup_config, 2'h2);
        ext_u.cfg_pins = 2'h1;
        watch(4);
        check("cfg_held", startup_config, 2'h2);
        $display("test reset done");
    endtask
    task automatic t_spike_osc();
        ext_u.glitch_reset();
        watch(4);
        check("glitch", 8'(seen), 8'h00);
        ext_u.hold_reset(1, 2'h1);
        watch(8);
        check("spike", 8'(seen), 8'h00);
        check("cfg_kept", startup_config, 2'h2);
        osc_running = 1'b0;
        ext_u.hold_reset(8, 2'h1);
        // oscillator stays off until the pin's high has passed the filter
        watch(4);
        check("osc_off_hold", 8'(seen), 8'h00);
        osc_running = 1'b1;
        watch(6);
        check("osc_off", 8'(seen), 8'h00);
        $display("test spike done");
    endtask
    task automatic t_trap_pd();
        ext_u.set_trap(1'b0);
        seen = 0;
        repeat (5) begin
            @(posedge clock) #5;
            seen += int'(nmi_trap === 1'b1);
        end
        check("trap_pulse", 8'(seen), 8'h01);
        ext_u.set_trap(1'b1);
        watch(3);
        pulse_pd();
        check("pd_refused", power_down, 1'b0);
        ext_u.set_trap(1'b0);
        watch(3);
        pulse_pd();
        check("pd_entered", power_down, 1'b1);
        ext_u.hold_reset(8, 2'h3);
        check("pd_exit", power_down, 1'b0);
        watch(6);
        check("cfg_again", startup_config, 2'h3);
        $display("test trap done");
    endtask
    initial begin
        resetn = 1'b0;
        osc_running = 1'b1;
        pd_instr = 1'b0;
        repeat (5) @(posedge clock);
        #5 resetn = 1'b1;
        watch(2);
        t_reset();
        t_spike_osc();
        t_trap_pd();
        summarize();
    end
    // cut a hang short
    initial begin
        #200000;
        bad_count++;
        summarize();
    end
endmodule
